// >>> pdra_access.sv
// Register access over the cyclic process image: control byte and
// output word in, status byte and input word out.
// Assumes one new exchange is flagged by a single-cycle pi_strobe and
// that the master holds each request until it sees the acknowledge.
`timescale 1ns/1ns
module pdra_access
  import pdra_pkg::*;
#(
  parameter logic [pdra_pkg::WORD_W-1:0] FW_VERSION = 16'h3130
)(
  // Clock and reset
  input  wire logic                          mclk,
  input  wire logic                          sys_rst,
  input  wire logic                          cfg_init,
  // Process image from the master
  input  wire logic                          pi_strobe,
  input  wire logic [pdra_pkg::BYTE_W-1:0]   pi_ctrl,
  input  wire logic [pdra_pkg::BYTE_W-1:0]   pi_out_hi,
  input  wire logic [pdra_pkg::BYTE_W-1:0]   pi_out_lo,
  // Measurement data for normal mode
  input  wire logic [pdra_pkg::BYTE_W-1:0]   meas_status,
  input  wire logic [pdra_pkg::WORD_W-1:0]   meas_word,
  // Process image to the master
  output logic                               po_valid_r,
  output logic      [pdra_pkg::BYTE_W-1:0]   po_status_r,
  output logic      [pdra_pkg::BYTE_W-1:0]   po_in_hi_r,
  output logic      [pdra_pkg::BYTE_W-1:0]   po_in_lo_r,
  // Block state
  output logic                               wr_unlocked_r,
  output logic                               wr_reject_r,
  output logic      [pdra_pkg::WORD_W-1:0]   feat_active_r
);
  import pdra_pkg::*;

  pdra_state_t          state_r;
  pdra_state_t          state_nxt;
  logic [BYTE_W-1:0]    req_ctrl_r;
  logic [WORD_W-1:0]    req_word_r;
  logic                 req_reg_mode;
  logic                 req_write;
  logic [ADDR_W-1:0]    req_addr;
  logic                 wr_allowed;
  logic                 st_wr_en;
  logic [WORD_W-1:0]    rd_data;
  logic [WORD_W-1:0]    feat_stored;
  logic                 exec;

  ////////////////////////////////////////////////////////////////////////////
  // Request decode
  assign exec         = (state_r == PDRA_EXEC);
  assign req_reg_mode = req_ctrl_r[CTRL_REG_BIT];
  assign req_write    = req_ctrl_r[CTRL_WR_BIT];
  assign req_addr     = req_ctrl_r[CTRL_ADDR_HI:CTRL_ADDR_LO];

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer: take one exchange, then answer it
  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      PDRA_IDLE:
      begin
        if (pi_strobe)
        begin
          state_nxt = PDRA_EXEC;
        end
      end
      PDRA_EXEC:
      begin
        state_nxt = PDRA_IDLE;
      end
      default:
      begin
        state_nxt = PDRA_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      state_r <= PDRA_IDLE;
    end
    else
    begin
      state_r <= state_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Request capture; the word arrives high byte first
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      req_ctrl_r <= RST_BYTE;
      req_word_r <= RST_REG_VALUE;
    end
    else if (state_r == PDRA_IDLE && pi_strobe)
    begin
      req_ctrl_r <= pi_ctrl;
      req_word_r <= {pi_out_hi, pi_out_lo};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Write protection
  always_comb
  begin
    if (req_addr == REG_UNLOCK)
    begin
      wr_allowed = 1'b1;
    end
    else if (req_addr == REG_FW_VERSION)
    begin
      wr_allowed = 1'b0;
    end
    else
    begin
      wr_allowed = wr_unlocked_r;
    end
  end

  // Only a write request touches the store; reads leave the word unused
  assign st_wr_en = exec && req_reg_mode && req_write && wr_allowed;

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      wr_unlocked_r <= 1'b0;
    end
    else if (exec && req_reg_mode && req_write && req_addr == REG_UNLOCK)
    begin
      wr_unlocked_r <= (req_word_r == UNLOCK_CODE);
    end
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      wr_reject_r <= 1'b0;
    end
    else
    begin
      wr_reject_r <= exec && req_reg_mode && req_write && !wr_allowed;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register store
  pdra_reg_store #(
    .ADDR_W_P   (ADDR_W),
    .DATA_W_P   (WORD_W),
    .FW_VERSION (FW_VERSION)
  ) u_store (
    .mclk      (mclk),
    .cfg_init  (cfg_init),
    .wr_en     (st_wr_en),
    .wr_addr   (req_addr),
    .wr_data   (req_word_r),
    .rd_addr   (req_addr),
    .rd_data   (rd_data),
    .feat_data (feat_stored)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Answer to the master
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      po_status_r <= RST_STATUS;
      po_in_hi_r  <= RST_BYTE;
      po_in_lo_r  <= RST_BYTE;
    end
    else if (exec)
    begin
      if (!req_reg_mode)
      begin
        po_status_r <= meas_status;
        po_in_hi_r  <= meas_word[WORD_W-1:BYTE_W];
        po_in_lo_r  <= meas_word[BYTE_W-1:0];
      end
      else if (req_write)
      begin
        po_status_r <= req_ctrl_r & WR_ACK_MASK;
        po_in_hi_r  <= WR_DATA_FILL[WORD_W-1:BYTE_W];
        po_in_lo_r  <= WR_DATA_FILL[BYTE_W-1:0];
      end
      else
      begin
        po_status_r <= req_ctrl_r;
        po_in_hi_r  <= rd_data[WORD_W-1:BYTE_W];
        po_in_lo_r  <= rd_data[BYTE_W-1:0];
      end
    end
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      po_valid_r <= 1'b0;
    end
    else
    begin
      po_valid_r <= exec;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Settings in force; taken from the store only at restart
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      if (cfg_init)
      begin
        feat_active_r <= RST_FEATURE;
      end
      else
      begin
        feat_active_r <= feat_stored;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (sys_rst);

  property p_take;
    (state_r == PDRA_IDLE) && pi_strobe |-> ##2 po_valid_r;
  endproperty
  a_take: assert property (p_take)
    else $error("exchange not answered two cycles after strobe");

  property p_normal;
    exec && !req_reg_mode |=>
      po_status_r == $past(meas_status) &&
      {po_in_hi_r, po_in_lo_r} == $past(meas_word) && !$past(st_wr_en);
  endproperty
  a_normal: assert property (p_normal)
    else $error("normal mode answer not taken from measurement");

  property p_rd_ack;
    exec && req_reg_mode && !req_write |=>
      po_status_r == $past(req_ctrl_r) && po_valid_r;
  endproperty
  a_rd_ack: assert property (p_rd_ack)
    else $error("read acknowledge differs from control byte");

  property p_rd_data;
    exec && req_reg_mode && !req_write |=>
      po_in_hi_r == $past(rd_data[WORD_W-1:BYTE_W]) &&
      po_in_lo_r == $past(rd_data[BYTE_W-1:0]);
  endproperty
  a_rd_data: assert property (p_rd_data)
    else $error("read data not returned high byte first");

  property p_wr_ack;
    exec && req_reg_mode && req_write |=>
      po_status_r[CTRL_WR_BIT] == 1'b0 &&
      po_status_r[CTRL_REG_BIT] == 1'b1 &&
      po_status_r[CTRL_ADDR_HI:CTRL_ADDR_LO] == $past(req_addr);
  endproperty
  a_wr_ack: assert property (p_wr_ack)
    else $error("write acknowledge wrong");

  property p_ignore;
    exec && req_reg_mode && !req_write |-> !st_wr_en;
  endproperty
  a_ignore: assert property (p_ignore)
    else $error("read request wrote the store");

  property p_lock;
    st_wr_en && req_addr != REG_UNLOCK |->
      wr_unlocked_r && req_addr != REG_FW_VERSION;
  endproperty
  a_lock: assert property (p_lock)
    else $error("protected register written while locked");

  property p_unlock;
    exec && req_reg_mode && req_write && req_addr == REG_UNLOCK &&
      req_word_r == UNLOCK_CODE |=> wr_unlocked_r ##1 wr_unlocked_r;
  endproperty
  a_unlock: assert property (p_unlock)
    else $error("code word did not unlock");

  property p_relock;
    exec && req_reg_mode && req_write && req_addr == REG_UNLOCK &&
      req_word_r != UNLOCK_CODE |=> !wr_unlocked_r;
  endproperty
  a_relock: assert property (p_relock)
    else $error("other value did not relock");

  property p_active;
    !$past(sys_rst) |-> $stable(feat_active_r);
  endproperty
  a_active: assert property (p_active)
    else $error("settings changed without restart");

  property p_fw;
    exec && req_reg_mode && !req_write && req_addr == REG_FW_VERSION |=>
      {po_in_hi_r, po_in_lo_r} == FW_VERSION;
  endproperty
  a_fw: assert property (p_fw)
    else $error("version register wrong");

  property p_feat;
    exec && req_reg_mode && req_write && req_addr == REG_FEATURE &&
      wr_unlocked_r |-> st_wr_en ##1 (feat_stored == $past(req_word_r));
  endproperty
  a_feat: assert property (p_feat)
    else $error("unlocked feature write not stored");

  property p_reject;
    exec && req_reg_mode && req_write && req_addr != REG_UNLOCK &&
      !wr_unlocked_r |=> wr_reject_r;
  endproperty
  a_reject: assert property (p_reject)
    else $error("locked write not flagged as refused");

  property p_wr_fill;
    exec && req_reg_mode && req_write |=>
      {po_in_hi_r, po_in_lo_r} == WR_DATA_FILL;
  endproperty
  a_wr_fill: assert property (p_wr_fill)
    else $error("input word after write not filled");

  property p_pulse;
    po_valid_r |=> !po_valid_r;
  endproperty
  a_pulse: assert property (p_pulse)
    else $error("answer strobe longer than one cycle");

  property p_hold;
    !exec |=> $stable(po_status_r) && $stable(po_in_hi_r) &&
      $stable(po_in_lo_r);
  endproperty
  a_hold: assert property (p_hold)
    else $error("answer changed without an exchange");

endmodule

// >>> pdra_master.sv
// Fieldbus master model: issues one register or normal-mode exchange.
// Assumes the block answers with a one-cycle po_valid_r pulse.
`timescale 1ns/1ns
module pdra_master
  import pdra_pkg::*;
(
  // Clock
  input  wire logic                        mclk,
  // Request to the block
  output logic                             pi_strobe,
  output logic      [pdra_pkg::BYTE_W-1:0] pi_ctrl,
  output logic      [pdra_pkg::BYTE_W-1:0] pi_out_hi,
  output logic      [pdra_pkg::BYTE_W-1:0] pi_out_lo,
  // Answer from the block
  input  wire logic                        po_valid_r,
  output logic                             stall_err
);
  import pdra_pkg::*;

  initial
  begin
    pi_strobe = 1'b0;
    pi_ctrl   = 8'h00;
    pi_out_hi = 8'h00;
    pi_out_lo = 8'h00;
    stall_err = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic xfer(input logic [7:0] ctrl, input logic [15:0] w);
    int n;
    @(posedge mclk) #1;
    pi_strobe = 1'b1;
    pi_ctrl   = ctrl;
    {pi_out_hi, pi_out_lo} = w;
    @(posedge mclk) #1;
    pi_strobe = 1'b0;
    n = 0;
    // Request held until the acknowledge shows
    while (po_valid_r !== 1'b1 && n < 8)
    begin
      @(posedge mclk) #1;
      n++;
    end
    if (po_valid_r !== 1'b1)
      stall_err = 1'b1;
    // Released bytes carry no stale value
    pi_ctrl   = ~pi_ctrl;
    pi_out_hi = ~pi_out_hi;
    pi_out_lo = ~pi_out_lo;
  endtask
endmodule

// >>> pdra_pkg.sv
// Constants shared by the process data register access block.
// Assumes a single clock domain and a cyclic process image exchange.
//
// Contract
// - Control bit 7 selects register access mode
// - Bit 6 clear requests a register read
// - Bit 6 set writes output word to register
// - Bits 5..0 select one of 64 registers
// - Read acknowledge echoes control byte in status
// - Read returns addressed register in input word
// - Write acknowledge is control byte, bit 6 cleared
// - Output word ignored during a read
// - Words travel high byte first, low second
// - Locked: only register 31 accepts writes
// - Code 0x1235 into register 31 unlocks writes
// - Other value relocks; register 31 reads back
// - New settings act only after restart
// - Register 9 holds version as two characters
// - Unlocked feature register 32 stores and reads back
package pdra_pkg;

  localparam int BYTE_W = 8;
  localparam int WORD_W = 16;
  localparam int ADDR_W = 6;

  // Control byte layout
  localparam int CTRL_REG_BIT = 7;
  localparam int CTRL_WR_BIT  = 6;
  localparam int CTRL_ADDR_HI = 5;
  localparam int CTRL_ADDR_LO = 0;

  // Register numbers
  localparam logic [ADDR_W-1:0] REG_FW_VERSION = 6'h09;
  localparam logic [ADDR_W-1:0] REG_UNLOCK     = 6'h1F;
  localparam logic [ADDR_W-1:0] REG_FEATURE    = 6'h20;

  // Values
  localparam logic [WORD_W-1:0] UNLOCK_CODE   = 16'h1235;
  localparam logic [WORD_W-1:0] RST_REG_VALUE = 16'h0000;
  localparam logic [WORD_W-1:0] RST_FEATURE   = 16'h0000;
  localparam logic [WORD_W-1:0] WR_DATA_FILL  = 16'h0000;
  localparam logic [BYTE_W-1:0] WR_ACK_MASK   = 8'hBF;
  localparam logic [BYTE_W-1:0] RST_STATUS    = 8'h00;
  localparam logic [BYTE_W-1:0] RST_BYTE      = 8'h00;

  typedef enum logic [0:0] {
    PDRA_IDLE,
    PDRA_EXEC
  } pdra_state_t;

endpackage

// >>> pdra_reg_store.sv
// Register store: 64 words of retained settings plus a fixed version word.
// Assumes the owner gates writes; contents survive the block reset.
`timescale 1ns/1ns
module pdra_reg_store
  import pdra_pkg::*;
#(
  parameter int                ADDR_W_P   = pdra_pkg::ADDR_W,
  parameter int                DATA_W_P   = pdra_pkg::WORD_W,
  // Arbitrary version characters, "10"
  parameter logic [WORD_W-1:0] FW_VERSION = 16'h3130
)(
  // Clock and store initialisation
  input  wire logic                mclk,
  input  wire logic                cfg_init,
  // Write port
  input  wire logic                wr_en,
  input  wire logic [ADDR_W_P-1:0] wr_addr,
  input  wire logic [DATA_W_P-1:0] wr_data,
  // Read ports
  input  wire logic [ADDR_W_P-1:0] rd_addr,
  output logic      [DATA_W_P-1:0] rd_data,
  output logic      [DATA_W_P-1:0] feat_data
);

  localparam int DEPTH = 1 << ADDR_W_P;

  logic [DATA_W_P-1:0] mem [DEPTH];

  ////////////////////////////////////////////////////////////////////////////
  // Storage, loaded with defaults on initialisation
  always_ff @(posedge mclk)
  begin
    if (cfg_init)
    begin
      for (int i = 0; i < DEPTH; i++)
      begin
        mem[i] <= DATA_W_P'(RST_REG_VALUE);
      end
      mem[REG_FEATURE] <= DATA_W_P'(RST_FEATURE);
    end
    else if (wr_en)
    begin
      mem[wr_addr] <= wr_data;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read ports; the version word is fixed
  always_comb
  begin
    if (rd_addr == ADDR_W_P'(REG_FW_VERSION))
    begin
      rd_data = DATA_W_P'(FW_VERSION);
    end
    else
    begin
      rd_data = mem[rd_addr];
    end
  end

  assign feat_data = mem[REG_FEATURE];

endmodule

// >>> test_process_data_register_access.sv
// Self-checking bench for the register access block.
// Assumes pdra_master as the far side and a reference register image.
`timescale 1ns/1ns
module test_process_data_register_access;
  import pdra_pkg::*;

  typedef struct packed {
    logic [7:0]  st;
    logic [15:0] dat;
    logic        chk;
    logic        rej;
    logic        unl;
  } pdra_exp_t;

  // Arbitrary version characters
  localparam logic [15:0] FW = 16'h4B37;

  logic        mclk, sys_rst, cfg_init, pi_strobe, po_valid_r;
  logic        wr_unlocked_r, wr_reject_r, stall_err;
  logic [7:0]  pi_ctrl, pi_out_hi, pi_out_lo, meas_status;
  logic [7:0]  po_status_r, po_in_hi_r, po_in_lo_r;
  logic [15:0] meas_word, feat_active_r;
  logic [15:0] ref_mem [64];
  logic        unl;
  pdra_exp_t   expq [$];
  pdra_exp_t   got;
  int          mismatches, samples_checked;

  pdra_access #(.FW_VERSION(FW)) uut (
    .mclk(mclk), .sys_rst(sys_rst), .cfg_init(cfg_init),
    .pi_strobe(pi_strobe), .pi_ctrl(pi_ctrl),
    .pi_out_hi(pi_out_hi), .pi_out_lo(pi_out_lo),
    .meas_status(meas_status), .meas_word(meas_word),
    .po_valid_r(po_valid_r), .po_status_r(po_status_r),
    .po_in_hi_r(po_in_hi_r), .po_in_lo_r(po_in_lo_r),
    .wr_unlocked_r(wr_unlocked_r), .wr_reject_r(wr_reject_r),
    .feat_active_r(feat_active_r));

  pdra_master m (
    .mclk(mclk), .pi_strobe(pi_strobe), .pi_ctrl(pi_ctrl),
    .pi_out_hi(pi_out_hi), .pi_out_lo(pi_out_lo),
    .po_valid_r(po_valid_r), .stall_err(stall_err));

  initial
  begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      mismatches++;
    end
  endtask

  task close_out;
    $display("checked %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic do_rst(input logic init);
    @(posedge mclk) #1;
    sys_rst  = 1'b1;
    cfg_init = init;
    repeat (6) @(posedge mclk);
    #1;
    sys_rst  = 1'b0;
    cfg_init = 1'b0;
    unl      = 1'b0;
    if (init)
    begin
      foreach (ref_mem[i]) ref_mem[i] = 16'h0000;
      ref_mem[REG_FW_VERSION] = FW;
    end
    check({15'h0000, po_valid_r}, 16'h0000);
    check({15'h0000, wr_unlocked_r}, 16'h0000);
    check(feat_active_r, ref_mem[REG_FEATURE]);
  endtask

  // Predict the answer, queue it, then let the master run the exchange
  task automatic op(input logic [7:0] ctrl, input logic [15:0] w);
    pdra_exp_t   e;
    logic [5:0]  a;
    logic        ok;
    a     = ctrl[5:0];
    e.chk = 1'b1;
    e.rej = 1'b0;
    if (!ctrl[7])
    begin
      e.st  = meas_status;
      e.dat = meas_word;
    end
    else if (!ctrl[6])
    begin
      e.st  = ctrl;
      e.dat = ref_mem[a];
    end
    else
    begin
      e.st  = {ctrl[7], 1'b0, ctrl[5:0]};
      e.chk = 1'b0;
      ok    = (a == REG_UNLOCK) || (unl && a != REG_FW_VERSION);
      e.rej = !ok;
      if (ok)
        ref_mem[a] = w;
      if (a == REG_UNLOCK)
        unl = (w == UNLOCK_CODE);
    end
    e.unl = unl;
    expq.push_back(e);
    m.xfer(ctrl, w);
    check({15'h0000, stall_err}, 16'h0000);
    if (stall_err !== 1'b0)
      close_out();
  endtask

  ////////////////////////////////////////////////////////////////////////////
  always @(posedge mclk)
  begin
    #2;
    if (po_valid_r === 1'b1)
    begin
      if (expq.size() == 0)
        check(16'h0000, 16'h0001);
      else
      begin
        got = expq.pop_front();
        check({8'h00, po_status_r}, {8'h00, got.st});
        if (got.chk)
          check({po_in_hi_r, po_in_lo_r}, got.dat);
        check({15'h0000, wr_reject_r}, {15'h0000, got.rej});
        check({15'h0000, wr_unlocked_r}, {15'h0000, got.unl});
      end
    end
  end

  initial
  begin
    sys_rst     = 1'b1;
    cfg_init    = 1'b1;
    meas_status = 8'h00;
    meas_word   = 16'h0000;
    unl         = 1'b0;
    mismatches  = 0;
    samples_checked = 0;
    void'($urandom(82));
    do_rst(1'b1);
    $display("test reset done");
    op(8'h89, 16'($urandom()));
    op(8'hE0, 16'h0002);
    op(8'hA0, 16'($urandom()));
    op(8'hDF, UNLOCK_CODE);
    op(8'h9F, 16'($urandom()));
    op(8'hE0, 16'h0002);
    op(8'hA0, 16'($urandom()));
    op(8'hC9, 16'h5A5A);
    op(8'h89, 16'h0000);
    check(feat_active_r, 16'h0000);
    $display("test directed access done");
    do_rst(1'b0);
    check(feat_active_r, 16'h0002);
    $display("test restart done");
    for (int i = 0; i < 80; i++)
    begin
      meas_status = 8'($urandom());
      meas_word   = 16'($urandom());
      if ($urandom_range(3, 0) == 0)
        op({2'b11, REG_UNLOCK}, $urandom_range(1, 0) ? UNLOCK_CODE
                                 : 16'($urandom()));
      else
        op({$urandom_range(7, 0) != 0, 7'($urandom())},
           16'($urandom()));
    end
    repeat (4) @(posedge mclk);
    check(16'(expq.size()), 16'h0000);
    $display("test random access done");
    close_out();
  end
endmodule
